/* File: rtl/masked_burst_address_counter.sv */
// per-port burst address counter with programmable wrap mask
// Functional notes
// - wrap flag pulses low one cycle when the free field rolls over while stepping
// - mask accepts up to ffff; full mask spans whole address space
// - mask bit one frees the matching counter bit, bit 0 least significant
// - blocked counter bits keep the loaded value through every step
// - step advances only the free field; it rolls to zero, upper bits kept
// - mask bit 0 zero freezes counter bit 0; counter steps by two
// - mask bit 0 one steps the counter by one
// - controls sampled on port clock; global reset asynchronous, top priority
// - global reset clears counter and sets mask to all ones
// - counter clear zeroes the counter only, mask untouched
// - load pins capture address lines; mask load beats counter load
// - step advances counter each cycle, ranked just below the loads
// - readback drives counter or mask onto address lines; counter wins
// - readback has one idle cycle; value valid after the following edge
// - readback with port selected releases the data pins
// - all controls high holds the counter; hold is lowest priority
// - counter and mask operations ignore the port selects
// - stepping advances the counter on every rising port clock edge with ce_i high, srst_i low and global reset released, unless the mask is 0000
// - global reset wins over counter clear
`timescale 1ns/1ps
`default_nettype none

module masked_burst_address_counter (
    input  wire logic                                 clk_i,
    input  wire logic                                 ce_i,
    input  wire logic                                 srst_i,
    input  wire logic                                 global_reset_n_i,
    input  wire logic                                 counter_clear_n_i,
    input  wire logic                                 wrap_mask_load_n_i,
    input  wire logic                                 counter_load_n_i,
    input  wire logic                                 count_step_n_i,
    input  wire logic                                 counter_readback_n_i,
    input  wire logic                                 wrap_mask_readback_n_i,
    input  wire logic                                 port_select_low_n_i,
    input  wire logic                                 port_select_high_i,
    input  wire logic [burst_counter_pkg::ADDR_W-1:0] addr_i,
    output logic      [burst_counter_pkg::ADDR_W-1:0] addr_o,
    output logic                                      addr_oe_o,
    output logic                                      data_hiz_o,
    output logic                                      wrap_flag_n_o,
    output logic      [burst_counter_pkg::ADDR_W-1:0] counter_o,
    output logic      [burst_counter_pkg::ADDR_W-1:0] wrap_mask_o,
    output burst_counter_pkg::op_t                    op_o
);

    burst_counter_pkg::ctrl_t                ctrl;
    burst_counter_pkg::op_t                  op_nxt;
    burst_counter_pkg::rb_req_t              rb_req;
    logic [burst_counter_pkg::ADDR_W-1:0]    count_r;
    logic [burst_counter_pkg::ADDR_W-1:0]    mask_r;
    logic [burst_counter_pkg::ADDR_W-1:0]    step_value;
    logic                                    step_wraps;
    logic                                    port_enabled;

    assign ctrl = '{
        counter_clear_n:      counter_clear_n_i,
        wrap_mask_load_n:     wrap_mask_load_n_i,
        counter_load_n:       counter_load_n_i,
        count_step_n:         count_step_n_i,
        counter_readback_n:   counter_readback_n_i,
        wrap_mask_readback_n: wrap_mask_readback_n_i
    };

    // selects only steer the data pins, never the counter
    assign port_enabled = !port_select_low_n_i && port_select_high_i;

    // priority decode, left to right of the operation table
    always_comb begin
        if (!ctrl.counter_clear_n) begin
            op_nxt = burst_counter_pkg::OP_CLEAR;
        end else if (!ctrl.wrap_mask_load_n) begin
            op_nxt = burst_counter_pkg::OP_MASK_LOAD;
        end else if (!ctrl.counter_load_n) begin
            op_nxt = burst_counter_pkg::OP_CNT_LOAD;
        end else if (!ctrl.count_step_n) begin
            op_nxt = burst_counter_pkg::OP_STEP;
        end else if (!ctrl.counter_readback_n) begin
            op_nxt = burst_counter_pkg::OP_CNT_READ;
        end else if (!ctrl.wrap_mask_readback_n) begin
            op_nxt = burst_counter_pkg::OP_MASK_READ;
        end else begin
            op_nxt = burst_counter_pkg::OP_HOLD;
        end
    end

    masked_step u_step (
        .count_i (count_r),
        .mask_i  (mask_r),
        .next_o  (step_value),
        .wrap_o  (step_wraps)
    );

    // async global reset has top priority over everything, incl. srst
    always_ff @(posedge clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            count_r <= burst_counter_pkg::COUNTER_RESET_VAL;
        end else if (ce_i) begin
            if (srst_i) begin
                count_r <= burst_counter_pkg::COUNTER_RESET_VAL;
            end else begin
                unique case (op_nxt)
                    burst_counter_pkg::OP_CLEAR: begin
                        count_r <= burst_counter_pkg::COUNTER_RESET_VAL;
                    end
                    burst_counter_pkg::OP_CNT_LOAD: begin
                        count_r <= addr_i;
                    end
                    burst_counter_pkg::OP_STEP: begin
                        // bit 0 blocked gives steps of two, parity kept
                        count_r <= step_value;
                    end
                    burst_counter_pkg::OP_MASK_LOAD,
                    burst_counter_pkg::OP_CNT_READ,
                    burst_counter_pkg::OP_MASK_READ,
                    burst_counter_pkg::OP_HOLD: begin
                        count_r <= count_r;
                    end
                endcase
            end
        end
    end

    // mask is untouched by counter clear; full ffff frees every bit
    always_ff @(posedge clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            mask_r <= burst_counter_pkg::MASK_RESET_VAL;
        end else if (ce_i) begin
            if (srst_i) begin
                mask_r <= burst_counter_pkg::MASK_RESET_VAL;
            end else if (op_nxt == burst_counter_pkg::OP_MASK_LOAD) begin
                mask_r <= addr_i;
            end
        end
    end

    // active-low wrap pulse, one cycle per rollover
    always_ff @(posedge clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            wrap_flag_n_o <= burst_counter_pkg::FLAG_IDLE_N;
        end else if (ce_i) begin
            if (srst_i) begin
                wrap_flag_n_o <= burst_counter_pkg::FLAG_IDLE_N;
            end else begin
                wrap_flag_n_o <= !((op_nxt == burst_counter_pkg::OP_STEP)
                                   && step_wraps);
            end
        end
    end

    // counter mirror, one edge behind its flop so the output stays registered
    always_ff @(posedge clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            counter_o <= burst_counter_pkg::COUNTER_RESET_VAL;
        end else if (ce_i) begin
            if (srst_i) begin
                counter_o <= burst_counter_pkg::COUNTER_RESET_VAL;
            end else begin
                counter_o <= count_r;
            end
        end
    end

    // mask mirror, same lag as the counter mirror
    always_ff @(posedge clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            wrap_mask_o <= burst_counter_pkg::MASK_RESET_VAL;
        end else if (ce_i) begin
            if (srst_i) begin
                wrap_mask_o <= burst_counter_pkg::MASK_RESET_VAL;
            end else begin
                wrap_mask_o <= mask_r;
            end
        end
    end

    // operation taken at the last edge; reset shows hold
    always_ff @(posedge clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            op_o <= burst_counter_pkg::OP_HOLD;
        end else if (ce_i) begin
            if (srst_i) begin
                op_o <= burst_counter_pkg::OP_HOLD;
            end else begin
                op_o <= op_nxt;
            end
        end
    end

    // readback only when no higher operation is pending
    assign rb_req = '{
        active:       (op_nxt == burst_counter_pkg::OP_CNT_READ)
                      || (op_nxt == burst_counter_pkg::OP_MASK_READ),
        sel_mask:     (op_nxt == burst_counter_pkg::OP_MASK_READ),
        port_enabled: port_enabled
    };

    readback_stage u_readback (
        .clk_i            (clk_i),
        .ce_i             (ce_i),
        .srst_i           (srst_i),
        .global_reset_n_i (global_reset_n_i),
        .req_i            (rb_req),
        .count_i          (count_r),
        .mask_i           (mask_r),
        .addr_o           (addr_o),
        .addr_oe_o        (addr_oe_o),
        .data_hiz_o       (data_hiz_o)
    );

endmodule // masked_burst_address_counter

`default_nettype wire

/* File: rtl/burst_counter_pkg.sv */
// shared constants and types of the masked burst address counter
package burst_counter_pkg;

    localparam int unsigned ADDR_W = 16;

    localparam logic [ADDR_W-1:0] COUNTER_RESET_VAL = 16'h0000;
    localparam logic [ADDR_W-1:0] MASK_RESET_VAL    = 16'hffff;
    localparam logic [ADDR_W-1:0] MASK_MAX_VAL      = 16'hffff;
    localparam logic [ADDR_W-1:0] ADDR_IDLE_VAL     = 16'h0000;

    // bit that selects stepping by one or by two
    localparam int unsigned MASK_STEP_BIT = 0;

    localparam logic FLAG_IDLE_N = 1'b1;

    // one-hot operation codes, highest priority first after the resets
    typedef enum logic [6:0] {
        OP_CLEAR     = 7'h01,
        OP_MASK_LOAD = 7'h02,
        OP_CNT_LOAD  = 7'h04,
        OP_STEP      = 7'h08,
        OP_CNT_READ  = 7'h10,
        OP_MASK_READ = 7'h20,
        OP_HOLD      = 7'h40
    } op_t;

    // active-low control pins of one port as sampled on the port clock
    typedef struct packed {
        logic counter_clear_n;
        logic wrap_mask_load_n;
        logic counter_load_n;
        logic count_step_n;
        logic counter_readback_n;
        logic wrap_mask_readback_n;
    } ctrl_t;

    // readback request handed to the output stage
    typedef struct packed {
        logic active;
        logic sel_mask;
        logic port_enabled;
    } rb_req_t;

endpackage : burst_counter_pkg

/* File: rtl/masked_step.sv */
// combinational masked increment and wrap detection
`timescale 1ns/1ps
`default_nettype none

module masked_step (
    input  wire logic [burst_counter_pkg::ADDR_W-1:0] count_i,
    input  wire logic [burst_counter_pkg::ADDR_W-1:0] mask_i,
    output logic      [burst_counter_pkg::ADDR_W-1:0] next_o,
    output logic                                      wrap_o
);

    logic [burst_counter_pkg::ADDR_W-1:0] filled;
    logic [burst_counter_pkg::ADDR_W-1:0] sum;

    // blocked bits forced to one so the carry skips over them
    assign filled = count_i | ~mask_i;
    assign sum    = filled + 16'h0001;

    genvar b;
    generate
        for (b = 0; b < burst_counter_pkg::ADDR_W; b = b + 1) begin : g_bit
            // free bits take the sum, blocked bits keep the loaded value
            assign next_o[b] = mask_i[b] ? sum[b] : count_i[b];
        end
    endgenerate

    // free field all ones: the next step rolls it to zero
    assign wrap_o = &filled;

endmodule // masked_step

`default_nettype wire

/* File: rtl/readback_stage.sv */
// one-cycle readback pipeline driving the address lines
`timescale 1ns/1ps
`default_nettype none

module readback_stage (
    input  wire logic                                 clk_i,
    input  wire logic                                 ce_i,
    input  wire logic                                 srst_i,
    input  wire logic                                 global_reset_n_i,
    input  wire burst_counter_pkg::rb_req_t           req_i,
    input  wire logic [burst_counter_pkg::ADDR_W-1:0] count_i,
    input  wire logic [burst_counter_pkg::ADDR_W-1:0] mask_i,
    output logic      [burst_counter_pkg::ADDR_W-1:0] addr_o,
    output logic                                      addr_oe_o,
    output logic                                      data_hiz_o
);

    burst_counter_pkg::rb_req_t pend_r;

    // request held through the no-operation cycle
    always_ff @(posedge clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            pend_r <= '0;
        end else if (ce_i) begin
            if (srst_i) begin
                pend_r <= '0;
            end else begin
                pend_r <= req_i;
            end
        end
    end

    // value appears one edge after the request edge
    always_ff @(posedge clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            addr_o    <= burst_counter_pkg::ADDR_IDLE_VAL;
            addr_oe_o <= 1'b0;
        end else if (ce_i) begin
            if (srst_i) begin
                addr_o    <= burst_counter_pkg::ADDR_IDLE_VAL;
                addr_oe_o <= 1'b0;
            end else begin
                addr_oe_o <= pend_r.active;
                addr_o    <= pend_r.sel_mask ? mask_i : count_i;
            end
        end
    end

    // data pins released for the whole readback while the port is selected
    always_ff @(posedge clk_i or negedge global_reset_n_i) begin
        if (!global_reset_n_i) begin
            data_hiz_o <= 1'b0;
        end else if (ce_i) begin
            if (srst_i) begin
                data_hiz_o <= 1'b0;
            end else begin
                data_hiz_o <= (req_i.active && req_i.port_enabled)
                            || (pend_r.active && pend_r.port_enabled);
            end
        end
    end

endmodule // readback_stage

`default_nettype wire

/* File: tb/masked_burst_address_counter_sva.sv */
// port-level assertions of the masked burst address counter
`timescale 1ns/1ps
`default_nettype none
module masked_burst_address_counter_sva (
    input wire logic        clk_i,
    input wire logic        ce_i,
    input wire logic        srst_i,
    input wire logic        global_reset_n_i,
    input wire logic        counter_clear_n_i,
    input wire logic        wrap_mask_load_n_i,
    input wire logic        counter_load_n_i,
    input wire logic        count_step_n_i,
    input wire logic        counter_readback_n_i,
    input wire logic        wrap_mask_readback_n_i,
    input wire logic        port_select_low_n_i,
    input wire logic        port_select_high_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] addr_o,
    input wire logic        addr_oe_o,
    input wire logic        data_hiz_o,
    input wire logic        wrap_flag_n_o,
    input wire logic [15:0] counter_o,
    input wire logic [15:0] wrap_mask_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i || !global_reset_n_i || !ce_i);
    logic no_load, step, rd_any;
    assign no_load = counter_clear_n_i && wrap_mask_load_n_i && counter_load_n_i;
    assign step    = no_load && !count_step_n_i;
    assign rd_any  = no_load && count_step_n_i && !(counter_readback_n_i && wrap_mask_readback_n_i);
    function automatic logic [15:0] inc(input logic [15:0] c, input logic [15:0] m);
        return (((c | ~m) + 16'h0001) & m) | (c & ~m);
    endfunction
    sequence s_step; step; endsequence
    sequence s_cnt_rd; rd_any && !counter_readback_n_i; endsequence
    sequence s_mask_rd; rd_any && counter_readback_n_i; endsequence
    AST_CLEAR: assert property (!counter_clear_n_i |-> ##2 counter_o == 16'h0000 && $stable(wrap_mask_o))
        else $error("counter clear failed");
    AST_MASK_LOAD: assert property (counter_clear_n_i && !wrap_mask_load_n_i |-> ##2 wrap_mask_o == $past(addr_i, 2) && $stable(counter_o))
        else $error("mask load failed");
    AST_CNT_LOAD: assert property (counter_clear_n_i && wrap_mask_load_n_i && !counter_load_n_i |-> ##2 counter_o == $past(addr_i, 2))
        else $error("counter load failed");
    AST_STEP: assert property (s_step ##1 1'b1 |=> counter_o == inc($past(counter_o), $past(wrap_mask_o)))
        else $error("masked step wrong");
    AST_WRAP: assert property (s_step |=> wrap_flag_n_o == ((counter_o | ~wrap_mask_o) != 16'hffff))
        else $error("wrap flag wrong on step");
    AST_NO_WRAP: assert property (!step |=> wrap_flag_n_o)
        else $error("wrap flag without step");
    AST_CNT_RD: assert property (s_cnt_rd |-> ##2 addr_oe_o && addr_o == counter_o)
        else $error("counter readback wrong");
    AST_MASK_RD: assert property (s_mask_rd |-> ##2 addr_oe_o && addr_o == wrap_mask_o)
        else $error("mask readback wrong");
    AST_NO_RD: assert property (!rd_any |-> ##2 !addr_oe_o)
        else $error("address lines driven without readback");
    AST_HIZ: assert property (rd_any && !port_select_low_n_i && port_select_high_i |=> data_hiz_o [*2])
        else $error("data pins not released");
    AST_NO_HIZ: assert property (!rd_any ##1 !rd_any |=> !data_hiz_o)
        else $error("data pins released without readback");
    AST_HOLD: assert property (no_load && count_step_n_i |-> ##2 $stable(counter_o) && $stable(wrap_mask_o))
        else $error("hold changed state");
endmodule // masked_burst_address_counter_sva
bind masked_burst_address_counter masked_burst_address_counter_sva u_sva (.clk_i, .ce_i, .srst_i,
    .global_reset_n_i, .counter_clear_n_i, .wrap_mask_load_n_i, .counter_load_n_i, .count_step_n_i,
    .counter_readback_n_i, .wrap_mask_readback_n_i, .port_select_low_n_i, .port_select_high_i,
    .addr_i, .addr_o, .addr_oe_o, .data_hiz_o, .wrap_flag_n_o, .counter_o, .wrap_mask_o);
`default_nettype wire

/* File: tb/host_model.sv */
// host side driver of one port's counter control pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic               clk_i,
    output burst_counter_pkg::ctrl_t ctrl_o,
    output logic [15:0]             addr_o,
    output logic [1:0]              sel_o
);
    initial begin
        ctrl_o = 6'h3f;
        addr_o = 16'h0000;
        sel_o  = 2'b01;
    end
    // one request per cycle, launched after the falling edge and held a full cycle
    task automatic drive(input logic [5:0] c, input logic [15:0] a, input logic [1:0] s);
        @(negedge clk_i);
        ctrl_o <= c;
        addr_o <= a;
        sel_o  <= s;
    endtask
endmodule // host_model
`default_nettype wire

/* File: tb/masked_burst_address_counter_tb_top.sv */
// self-checking bench of the masked burst address counter
`timescale 1ns/1ps
`default_nettype none
module masked_burst_address_counter_tb_top;
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] mask;
        logic        fl;
        logic [6:0]  op;
        logic [1:0]  rb;
        logic        hz;
    } note_t;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic grst_n = 1'b1;
    logic ce = 1'b1;
    burst_counter_pkg::ctrl_t ctrl;
    burst_counter_pkg::op_t op;
    logic [15:0] a_in, a_out, cnt_out, mask_out;
    logic [15:0] rc = 16'h0000;
    logic [15:0] rm = 16'hffff;
    logic [15:0] rnd = 16'h0032;
    logic [1:0] sel;
    logic oe, hz, fl_n, have_prev;
    note_t q[$];
    note_t prev, n;
    int error_cnt = 0;
    int total_checks = 0;
    logic [15:0] masks [5] = '{16'h003f, 16'h000e, 16'hffff, 16'h0000, 16'h00f1};
    logic [5:0] ops [10] = '{6'h1f, 6'h2f, 6'h37, 6'h3b, 6'h3d, 6'h3e, 6'h3c, 6'h27, 6'h0f, 6'h3f};
    host_model u_host_model (.clk_i(clk_i), .ctrl_o(ctrl), .addr_o(a_in), .sel_o(sel));
    masked_burst_address_counter u_masked_burst_address_counter (
        .clk_i(clk_i), .ce_i(ce), .srst_i(srst_i), .global_reset_n_i(grst_n),
        .counter_clear_n_i(ctrl.counter_clear_n), .wrap_mask_load_n_i(ctrl.wrap_mask_load_n),
        .counter_load_n_i(ctrl.counter_load_n), .count_step_n_i(ctrl.count_step_n),
        .counter_readback_n_i(ctrl.counter_readback_n),
        .wrap_mask_readback_n_i(ctrl.wrap_mask_readback_n), .port_select_low_n_i(sel[0]),
        .port_select_high_i(sel[1]), .addr_i(a_in), .addr_o(a_out), .addr_oe_o(oe),
        .data_hiz_o(hz), .wrap_flag_n_o(fl_n), .counter_o(cnt_out), .wrap_mask_o(mask_out),
        .op_o(op));
    initial forever #12.5 clk_i = ~clk_i;
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // drive one request and note what the port must show for it
    task automatic do_op(input logic [5:0] c, input logic [15:0] a);
        note_t e;
        int k;
        rnd = lfsr(rnd);
        u_host_model.drive(c, a, rnd[1:0]);
        k = 0;
        while (k < 6 && c[5-k]) k++;
        e = '{cnt: rc, mask: rm, fl: 1'b1, op: 7'h01 << k, rb: 2'd0, hz: 1'b0};
        case (k)
            0: rc = 16'h0000;
            1: rm = a;
            2: rc = a;
            3: begin
                e.fl = (rc | ~rm) != 16'hffff;
                rc = (((rc | ~rm) + 16'h0001) & rm) | (rc & ~rm);
            end
            4, 5: begin
                e.rb = 2'(k - 3);
                e.hz = !rnd[0] && rnd[1];
            end
            default: ;
        endcase
        e.cnt = rc;
        e.mask = rm;
        q.push_back(e);
    endtask
    always @(posedge clk_i) begin
        #1;
        if (srst_i || !grst_n) begin
            have_prev = 1'b0;
            q.delete();
        end else begin
            if (have_prev) begin
                check(cnt_out, prev.cnt, "counter");
                check(mask_out, prev.mask, "mask");
                check({15'h0000, oe}, {15'h0000, prev.rb != 2'd0}, "address enable");
                if (prev.rb != 2'd0) check(a_out, prev.rb[0] ? prev.cnt : prev.mask, "readback");
            end
            if (q.size() > 0) begin
                n = q.pop_front();
                check({15'h0000, fl_n}, {15'h0000, n.fl}, "wrap flag");
                check({9'h000, op}, {9'h000, n.op}, "operation");
                check({15'h0000, hz}, {15'h0000, n.hz | (have_prev & prev.hz)}, "data release");
                prev = n;
                have_prev = 1'b1;
            end else have_prev = 1'b0;
        end
    end
    initial begin
        #20000;
        error_cnt++;
        stop_test();
    end
    initial begin
        have_prev = 1'b0;
        repeat (8) @(posedge clk_i);
        #1;
        check(cnt_out, 16'h0000, "reset counter");
        check(mask_out, 16'hffff, "reset mask");
        @(negedge clk_i);
        srst_i = 1'b0;
        foreach (masks[i]) begin
            rnd = lfsr(rnd);
            do_op(6'h2f, masks[i]);
            do_op(6'h37, (rnd & ~masks[i]) | (masks[i] & 16'hfffa));
            repeat (10) do_op(6'h3b, rnd);
        end
        foreach (ops[i]) do_op(ops[i], lfsr(rnd));
        repeat (60) begin
            rnd = lfsr(rnd);
            do_op(rnd[7:2] | {rnd[9:8], 4'h0}, rnd);
        end
        do_op(6'h3f, 16'h0000);
        #5 grst_n = 1'b0;
        #2;
        check(cnt_out, 16'h0000, "master reset counter");
        check(mask_out, 16'hffff, "master reset mask");
        u_host_model.drive(6'h1f, 16'h0000, 2'b01);
        @(posedge clk_i);
        #1;
        check(mask_out, 16'hffff, "mask under both resets");
        check({9'h000, op}, {9'h000, 7'h40}, "operation under both resets");
        @(negedge clk_i);
        grst_n = 1'b1;
        rc = 16'h0000;
        rm = 16'hffff;
        do_op(6'h37, 16'hfffe);
        repeat (3) do_op(6'h3b, 16'h0000);
        repeat (3) do_op(6'h3f, 16'h0000);
        // clock enable low: a step request must leave every flop frozen
        u_host_model.drive(6'h3b, 16'h0000, 2'b01);
        ce = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        check(cnt_out, rc, "frozen counter");
        check({9'h000, op}, {9'h000, 7'h40}, "frozen operation");
        u_host_model.drive(6'h3f, 16'h0000, 2'b01);
        ce = 1'b1;
        @(posedge clk_i);
        #2;
        stop_test();
    end
endmodule // masked_burst_address_counter_tb_top
`default_nettype wire
